/* inc/amc_defines.svh */
// Offsets, field positions, reset values and timing counts for mode control
`ifndef AMC_DEFINES_SVH
`define AMC_DEFINES_SVH
`define AMC_CLK_PERIOD_NS   20
`define AMC_DEBOUNCE_MS     16
`define AMC_DEBOUNCE_CYCLES ((`AMC_DEBOUNCE_MS * 1000000) / `AMC_CLK_PERIOD_NS)
`define AMC_REG_CABLE       8'h0A
`define AMC_REG_AUX         8'h13
`define AMC_REG_UFP_RX      8'h20
`define AMC_REG_UFP_TX      8'h21
`define AMC_REG_DFP_RX      8'h22
`define AMC_REG_DFP_TX      8'h23
`define AMC_USB_EN_BIT      0
`define AMC_ALT_EN_BIT      1
`define AMC_CABLE_BIT       6
`define AMC_AUX_OFF_BIT     7
`define AMC_CABLE_RST       8'h00
`define AMC_AUX_RST         8'h00
`define AMC_EQ_RST          8'h00
`define AMC_DEFAULT_LANES   3'h2
`define AMC_FULL_LANES      3'h4
`endif

/* inc/amc_pkg.sv */
// Types shared by the mode and equalization control
package amc_pkg;
  typedef enum logic [1:0] {
    AMC_LVL_LOW   = 2'b00,
    AMC_LVL_RGND  = 2'b01,
    AMC_LVL_FLOAT = 2'b10,
    AMC_LVL_HIGH  = 2'b11
  } amc_level_type;
  typedef enum logic [1:0] {
    AMC_EQ_UFP_RX = 2'b00,
    AMC_EQ_UFP_TX = 2'b01,
    AMC_EQ_DFP_RX = 2'b10,
    AMC_EQ_DFP_TX = 2'b11
  } amc_eq_slot_type;
endpackage : amc_pkg

/* src/amc_mode_ctrl.sv */
// Alternate mode, cable mode and receiver equalization control
`timescale 1ns/1ns
`include "amc_defines.svh"
// Operation
// - Custom alternate mode carries two or four channels up to 8.1 Gbps.
// - With I2C mode low, custom alternate mode follows the control pins.
// - In I2C mode, cable mode bit six of register cable_mode_control selects cable mode.
// - Cable mode: hot plug high gives DP, low gives USB only.
// - Cable mode picks the operating mode itself without outside commands.
// - Cable mode snoops AUX by default and takes one, two or four lanes.
// - Snooping off in cable mode gives two lanes while hot plug is high and USB is detected.
// - Cable mode settles on four lanes when hot plug is high and USB is not detected.
// - Equalization set per port, from straps or registers.
// - Two four-level straps per port give sixteen codes, 0,0 lowest.
// - Registers give the same sixteen codes per channel, port and direction.
// - Control and flip pins are debounced at least 16 ms.
module amc_mode_ctrl
  import amc_pkg::*;
#(
  parameter int DEBOUNCE_CYCLES = `AMC_DEBOUNCE_CYCLES
) (
  input  wire logic          i_clk,
  input  wire logic          i_reset,
  input  wire logic          i_i2c_mode,
  input  wire logic          i_usb_enable_pin,
  input  wire logic          i_dp_enable_pin,
  input  wire logic          i_flip_pin,
  input  wire logic          i_hot_plug_in,
  input  wire amc_level_type i_ufp_eq_sel_lo,
  input  wire amc_level_type i_ufp_eq_sel_hi,
  input  wire amc_level_type i_dfp_eq_sel_lo,
  input  wire amc_level_type i_dfp_eq_sel_hi,
  input  wire logic          i_aux_train_valid,
  input  wire logic [2:0]    i_aux_lane_count,
  input  wire logic          i_usb_detected,
  input  wire logic          i_reg_wr,
  input  wire logic          i_reg_rd,
  input  wire logic [7:0]    i_reg_addr,
  input  wire logic [7:0]    i_reg_wdata,
  output logic [7:0]         o_reg_rdata,
  output logic               o_cable_mode,
  output logic               o_usb_active,
  output logic               o_dp_active,
  output logic               o_alt_active,
  output logic [2:0]         o_lane_count,
  output logic               o_flip,
  output logic [7:0]         o_ufp_rx_eq_code,
  output logic [7:0]         o_ufp_tx_eq_code,
  output logic [7:0]         o_dfp_rx_eq_code,
  output logic [7:0]         o_dfp_tx_eq_code
);
  localparam int CW = $clog2(DEBOUNCE_CYCLES + 1);
  localparam logic [CW-1:0] DB_LAST = CW'(DEBOUNCE_CYCLES - 1);

  typedef struct packed {
    logic [3:0]      cand;
    logic [3:0]      stable;
    logic [CW-1:0]   cnt;
    logic            strap_done;
    logic [3:0]      ufp_strap;
    logic [3:0]      dfp_strap;
    logic [7:0]      cable_reg;
    logic [7:0]      aux_reg;
    logic [3:0][7:0] eq_reg;
    logic [7:0]      rdata;
    logic            cable;
    logic            usb;
    logic            dp;
    logic            alt;
    logic [2:0]      lanes;
    logic [3:0][7:0] eq_out;
  } amc_state_type;

  amc_state_type st_q;
  amc_state_type st_d;

  function automatic logic eq_hit(input logic [7:0] addr);
    return addr >= `AMC_REG_UFP_RX && addr <= `AMC_REG_DFP_TX;
  endfunction : eq_hit

  function automatic logic [1:0] lvl_index(input amc_level_type lvl);
    unique case (lvl)
      AMC_LVL_LOW:   return 2'h0;
      AMC_LVL_RGND:  return 2'h1;
      AMC_LVL_FLOAT: return 2'h2;
      AMC_LVL_HIGH:  return 2'h3;
    endcase
  endfunction : lvl_index

  logic       pin_usb;
  logic       pin_dp;
  logic       pin_hpd;
  logic       aux_off;
  logic [3:0] raw;

  assign raw     = {i_flip_pin, i_hot_plug_in, i_dp_enable_pin, i_usb_enable_pin};
  assign pin_usb = st_q.stable[0];
  assign pin_dp  = st_q.stable[1];
  assign pin_hpd = st_q.stable[2];
  assign aux_off = st_q.aux_reg[`AMC_AUX_OFF_BIT];

  always_comb begin
    st_d = st_q;
    // Debounce: a change must hold for the whole window before it is used
    if (raw != st_q.cand) begin
      st_d.cand = raw;
      st_d.cnt  = '0;
    end else if (st_q.cand != st_q.stable) begin
      if (st_q.cnt == DB_LAST) begin
        st_d.stable = st_q.cand;
        st_d.cnt    = '0;
      end else begin
        st_d.cnt = st_q.cnt + CW'(1);
      end
    end
    // Straps caught once after reset; later pin motion is ignored
    if (!st_q.strap_done) begin
      st_d.strap_done = 1'b1;
      st_d.ufp_strap  = {lvl_index(i_ufp_eq_sel_hi), lvl_index(i_ufp_eq_sel_lo)};
      st_d.dfp_strap  = {lvl_index(i_dfp_eq_sel_hi), lvl_index(i_dfp_eq_sel_lo)};
    end
    if (i_reg_wr) begin
      if (i_reg_addr == `AMC_REG_CABLE) begin
        st_d.cable_reg = i_reg_wdata;
      end
      if (i_reg_addr == `AMC_REG_AUX) begin
        st_d.aux_reg = i_reg_wdata;
      end
      if (eq_hit(i_reg_addr)) begin
        st_d.eq_reg[i_reg_addr[1:0]] = i_reg_wdata;
      end
    end
    if (i_reg_rd) begin
      if (i_reg_addr == `AMC_REG_CABLE) begin
        st_d.rdata = st_q.cable_reg;
      end else if (i_reg_addr == `AMC_REG_AUX) begin
        st_d.rdata = st_q.aux_reg;
      end else if (eq_hit(i_reg_addr)) begin
        st_d.rdata = st_q.eq_reg[i_reg_addr[1:0]];
      end else begin
        st_d.rdata = {5'h00, st_q.lanes};
      end
    end
    // Mode selection
    st_d.cable = i_i2c_mode ? st_q.cable_reg[`AMC_CABLE_BIT]
                            : (!pin_usb && !pin_dp);
    st_d.alt   = 1'b0;
    if (st_q.cable) begin
      // Mode follows hot plug and the snooped link, no outside command
      st_d.dp  = pin_hpd;
      st_d.usb = 1'b1;
      if (!pin_hpd) begin
        st_d.lanes = 3'h0;
      end else if (!i_usb_detected) begin
        st_d.usb   = 1'b0;
        st_d.lanes = `AMC_FULL_LANES;
      end else if (aux_off) begin
        st_d.lanes = `AMC_DEFAULT_LANES;
      end else if (i_aux_train_valid) begin
        st_d.lanes = i_aux_lane_count;
        st_d.usb   = i_aux_lane_count != `AMC_FULL_LANES;
      end else begin
        st_d.lanes = `AMC_DEFAULT_LANES;
      end
    end else begin
      st_d.dp  = 1'b0;
      st_d.usb = i_i2c_mode ? st_q.cable_reg[`AMC_USB_EN_BIT] : pin_usb;
      // In register mode the alternate path stays off until the monitor bit is clear
      st_d.alt = i_i2c_mode ? (st_q.cable_reg[`AMC_ALT_EN_BIT] && !aux_off)
                            : pin_dp;
      st_d.lanes = !st_d.alt ? 3'h0 : (st_d.usb ? 3'h2 : 3'h4);
    end
    // Equalization source per port
    for (int s = 0; s < 4; s++) begin
      if (i_i2c_mode) begin
        st_d.eq_out[s] = st_q.eq_reg[s];
      end else begin
        st_d.eq_out[s] = (s < 2) ? {2{st_q.ufp_strap}} : {2{st_q.dfp_strap}};
      end
    end
    if (i_reset) begin
      st_d            = '0;
      st_d.cand       = 4'h0;
      st_d.cable_reg  = `AMC_CABLE_RST;
      st_d.aux_reg    = `AMC_AUX_RST;
      st_d.eq_reg     = {4{`AMC_EQ_RST}};
    end
  end

  always_ff @(posedge i_clk) begin
    st_q <= st_d;
  end

  assign o_reg_rdata      = st_q.rdata;
  assign o_cable_mode     = st_q.cable;
  assign o_usb_active     = st_q.usb;
  assign o_dp_active      = st_q.dp;
  assign o_alt_active     = st_q.alt;
  assign o_lane_count     = st_q.lanes;
  assign o_flip           = st_q.stable[3];
  assign o_ufp_rx_eq_code = st_q.eq_out[AMC_EQ_UFP_RX];
  assign o_ufp_tx_eq_code = st_q.eq_out[AMC_EQ_UFP_TX];
  assign o_dfp_rx_eq_code = st_q.eq_out[AMC_EQ_DFP_RX];
  assign o_dfp_tx_eq_code = st_q.eq_out[AMC_EQ_DFP_TX];

  // Checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);

  property p_pin_cable;
    !i_i2c_mode && !pin_usb && !pin_dp |=> o_cable_mode;
  endproperty
  a_pin_cable: assert property (p_pin_cable) else $error("pin cable mode missed");

  property p_reg_cable;
    i_i2c_mode |=> o_cable_mode == $past(st_q.cable_reg[`AMC_CABLE_BIT]);
  endproperty
  a_reg_cable: assert property (p_reg_cable) else $error("register cable mode wrong");

  logic strap_ok;
  assign strap_ok = st_q.strap_done;

  property p_hpd_dp;
    o_cable_mode && strap_ok |=> o_dp_active == $past(pin_hpd);
  endproperty
  a_hpd_dp: assert property (p_hpd_dp) else $error("hot plug does not steer DP");

  property p_no_usb_four;
    o_cable_mode && pin_hpd && !i_usb_detected |=> o_lane_count == 3'h4 && !o_usb_active;
  endproperty
  a_no_usb_four: assert property (p_no_usb_four) else $error("four lanes not chosen");

  property p_snoop_off;
    o_cable_mode && pin_hpd && i_usb_detected && aux_off |=> o_lane_count == 3'h2;
  endproperty
  a_snoop_off: assert property (p_snoop_off) else $error("two lanes not chosen");

  property p_snoop_on;
    o_cable_mode && pin_hpd && i_usb_detected && !aux_off && i_aux_train_valid
      |=> o_lane_count == $past(i_aux_lane_count);
  endproperty
  a_snoop_on: assert property (p_snoop_on) else $error("snooped lanes ignored");

  property p_aux_gate;
    i_i2c_mode && aux_off |=> !o_alt_active;
  endproperty
  a_aux_gate: assert property (p_aux_gate) else $error("alt mode with monitor off");

  property p_pin_alt;
    !i_i2c_mode && !o_cable_mode |=> o_alt_active == $past(pin_dp);
  endproperty
  a_pin_alt: assert property (p_pin_alt) else $error("alt mode not from pins");

  property p_strap_hold;
    st_q.strap_done |=> $stable(st_q.ufp_strap) && $stable(st_q.dfp_strap);
  endproperty
  a_strap_hold: assert property (p_strap_hold) else $error("strap code moved");

  property p_strap_out;
    !i_i2c_mode && strap_ok |=> o_dfp_rx_eq_code == {2{$past(st_q.dfp_strap)}};
  endproperty
  a_strap_out: assert property (p_strap_out) else $error("strap code not applied");

  property p_debounce;
    raw != st_q.stable |=> $stable(st_q.stable) || $past(st_q.cnt) == DB_LAST;
  endproperty
  a_debounce: assert property (p_debounce) else $error("pin change taken early");
endmodule : amc_mode_ctrl

/* sim/amc_pd_model.sv */
// Behavioural model of the controller that drives the mode control pins
`timescale 1ns/1ns
module amc_pd_model (
  input  wire logic       i_clk,
  output logic            o_usb_enable_pin,
  output logic            o_dp_enable_pin,
  output logic            o_hot_plug_in,
  output logic            o_flip_pin,
  output logic            o_aux_train_valid,
  output logic [2:0]      o_aux_lane_count,
  output logic            o_usb_detected
);
  // Pins idle low, which is also the pin request for cable mode
  initial begin
    {o_usb_enable_pin, o_dp_enable_pin, o_hot_plug_in, o_flip_pin} = 4'h0;
    {o_aux_train_valid, o_aux_lane_count, o_usb_detected} = 5'h00;
  end
  // Levels change just after an edge and then stand until the next call
  task set(input logic usb, dp, hpd, flip, vld, input logic [2:0] cnt, input logic det);
    @(posedge i_clk);
    #1;
    o_usb_enable_pin = usb;
    o_dp_enable_pin = dp;
    o_hot_plug_in = hpd;
    o_flip_pin = flip;
    o_aux_train_valid = vld;
    o_aux_lane_count = cnt;
    o_usb_detected = det;
  endtask : set
endmodule : amc_pd_model

/* sim/test_altmode_cable_eq_config.sv */
// Self-checking bench for alternate mode, cable mode and equalization control
`timescale 1ns/1ns
module test_altmode_cable_eq_config;
  import amc_pkg::*;
  logic i_clk, i_reset, i_i2c_mode, i_reg_wr, i_reg_rd, usb, dp, hpd, flip, vld, det;
  logic [2:0] cnt, o_lane_count;
  logic [7:0] i_reg_addr, i_reg_wdata, o_reg_rdata, ur, ut, dr, dt;
  logic o_cable_mode, o_usb_active, o_dp_active, o_alt_active, o_flip;
  amc_level_type ul, uh, dl, dh;
  int n_fail, cmp_count;
  amc_pd_model pd (.i_clk(i_clk), .o_usb_enable_pin(usb), .o_dp_enable_pin(dp),
    .o_hot_plug_in(hpd), .o_flip_pin(flip), .o_aux_train_valid(vld),
    .o_aux_lane_count(cnt), .o_usb_detected(det));
  // Short debounce keeps the run brief; waits below allow eight cycles plus pipeline
  amc_mode_ctrl #(.DEBOUNCE_CYCLES(8)) dut (.i_clk(i_clk), .i_reset(i_reset),
    .i_i2c_mode(i_i2c_mode), .i_usb_enable_pin(usb), .i_dp_enable_pin(dp),
    .i_flip_pin(flip), .i_hot_plug_in(hpd), .i_ufp_eq_sel_lo(ul), .i_ufp_eq_sel_hi(uh),
    .i_dfp_eq_sel_lo(dl), .i_dfp_eq_sel_hi(dh), .i_aux_train_valid(vld),
    .i_aux_lane_count(cnt), .i_usb_detected(det), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
    .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata),
    .o_cable_mode(o_cable_mode), .o_usb_active(o_usb_active), .o_dp_active(o_dp_active),
    .o_alt_active(o_alt_active), .o_lane_count(o_lane_count), .o_flip(o_flip),
    .o_ufp_rx_eq_code(ur), .o_ufp_tx_eq_code(ut), .o_dfp_rx_eq_code(dr),
    .o_dfp_tx_eq_code(dt));
  initial begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end
  task report_and_stop;
    if (n_fail == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : report_and_stop
  task chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task tick(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask : tick
  task wr(input logic [7:0] a, input logic [7:0] d);
    tick(1);
    {i_reg_wr, i_reg_addr, i_reg_wdata} = {1'b1, a, d};
    tick(1);
    i_reg_wr = 1'b0;
  endtask : wr
  task rd(input logic [7:0] a, input logic [7:0] exp);
    tick(1);
    {i_reg_rd, i_reg_addr} = {1'b1, a};
    tick(1);
    i_reg_rd = 1'b0;
    tick(1);
    chk(o_reg_rdata, exp);
  endtask : rd
  // Watchdog: a hang counts as a mismatch
  initial begin
    #400000;
    n_fail++;
    report_and_stop;
  end
  initial begin
    {i_reset, i_i2c_mode, i_reg_wr, i_reg_rd, i_reg_addr, i_reg_wdata} = 20'h80000;
    {n_fail, cmp_count} = 64'h0;
    ul = AMC_LVL_RGND;
    uh = AMC_LVL_FLOAT;
    dl = AMC_LVL_HIGH;
    dh = AMC_LVL_LOW;
    tick(5);
    i_reset = 1'b0;
    tick(2);
    // Straps are caught on the first edge after reset, so moving them now must not show
    ul = AMC_LVL_LOW;
    uh = AMC_LVL_LOW;
    dl = AMC_LVL_LOW;
    dh = AMC_LVL_LOW;
    rd(8'h0A, 8'h00);
    rd(8'h13, 8'h00);
    chk(ur, 8'h99);
    chk(dt, 8'h33);
    chk(ut, 8'h99);
    chk(dr, 8'h33);
    tick(14);
    chk(o_cable_mode, 1'b1);
    chk({o_usb_active, o_dp_active, o_lane_count}, 5'h10);
    pd.set(1'h0, 1'h0, 1'h1, 1'h1, 1'h0, 3'h0, 1'h1);
    tick(14);
    chk({o_dp_active, o_lane_count, o_flip}, 5'h15);
    pd.set(1'h0, 1'h0, 1'h1, 1'h1, 1'h1, 3'h1, 1'h1);
    tick(3);
    chk(o_lane_count, 3'h1);
    pd.set(1'h0, 1'h0, 1'h1, 1'h1, 1'h0, 3'h0, 1'h0);
    tick(3);
    chk({o_usb_active, o_lane_count}, 4'h4);
    pd.set(1'h0, 1'h1, 1'h1, 1'h1, 1'h0, 3'h0, 1'h0);
    tick(3);
    pd.set(1'h0, 1'h0, 1'h1, 1'h1, 1'h0, 3'h0, 1'h0);
    tick(14);
    chk(o_cable_mode, 1'b1);
    pd.set(1'h1, 1'h1, 1'h0, 1'h0, 1'h0, 3'h0, 1'h1);
    tick(14);
    chk({o_cable_mode, o_alt_active, o_flip}, 3'h2);
    chk({o_usb_active, o_lane_count}, 4'hA);
    i_i2c_mode = 1'b1;
    pd.set(1'h0, 1'h0, 1'h1, 1'h0, 1'h1, 3'h1, 1'h1);
    tick(14);
    wr(8'h0A, 8'h40);
    tick(3);
    chk(o_cable_mode, 1'b1);
    chk(o_lane_count, 3'h1);
    wr(8'h13, 8'h80);
    tick(3);
    chk(o_lane_count, 3'h2);
    rd(8'h13, 8'h80);
    rd(8'h55, 8'h02);
    for (int i = 0; i < 4; i++) wr(8'h20 + i[7:0], 8'hA5 + i[7:0]);
    tick(2);
    chk(ur, 8'hA5);
    chk(ut, 8'hA6);
    chk(dr, 8'hA7);
    chk(dt, 8'hA8);
    // Alternate mode asked for while the monitor is still off must stay dark
    wr(8'h0A, 8'h03);
    tick(3);
    chk({o_cable_mode, o_alt_active}, 2'h0);
    wr(8'h13, 8'h00);
    wr(8'h55, 8'hFF);
    tick(3);
    chk({o_cable_mode, o_alt_active}, 2'h1);
    chk({o_usb_active, o_lane_count}, 4'hA);
    rd(8'h0A, 8'h03);
    report_and_stop;
  end
endmodule : test_altmode_cable_eq_config
